// file: src/phy_irq_pkg.sv
// Purpose: shared constants and types of the status summary and interrupt logic
// Assumes: 16-bit management registers, 5-bit register address
// Notes:   event indices follow the bit order of the event status register

package phy_irq_pkg;

   localparam int          REG_W           = 16;
   localparam int          ADDR_W          = 5;
   localparam int          EVT_N           = 7;

   localparam logic [4:0]  ADDR_SUMMARY    = 5'h10;
   localparam logic [4:0]  ADDR_ICTRL      = 5'h11;
   localparam logic [4:0]  ADDR_ISTAT      = 5'h12;

   // summary status word bit positions
   localparam int          SUM_LINK        = 0;
   localparam int          SUM_LOW_SPEED_INDICATION     = 1;
   localparam int          SUM_DUPLEX      = 2;
   localparam int          SUM_LOOPBACK    = 3;
   localparam int          SUM_AN_DONE     = 4;
   localparam int          SUM_JABBER      = 5;
   localparam int          SUM_IRQ_PEND    = 7;

   // interrupt control word bit positions
   localparam int          CTL_IRQ_OE      = 0;
   localparam int          CTL_GLOBAL_EN   = 1;
   localparam int          CTL_TEST_FORCE  = 2;
   localparam int          CTL_USED_W      = 3;

   // event status word: flags in 14:8, enables in 6:0
   localparam int          ISTAT_FLAG_LSB  = 8;
   localparam int          ISTAT_EN_LSB    = 0;

   // event indices within the 7-bit flag and enable fields
   localparam int          EVT_RX_HALF     = 0;
   localparam int          EVT_FC_HALF     = 1;
   localparam int          EVT_AN_DONE     = 2;
   localparam int          EVT_DUPLEX      = 3;
   localparam int          EVT_SPEED       = 4;
   localparam int          EVT_LINK        = 5;
   localparam int          EVT_ENERGY      = 6;

   localparam logic [15:0] RST_WORD        = 16'h0000;
   localparam logic [6:0]  RST_EVT         = 7'h00;
   localparam logic [2:0]  RST_CTL         = 3'h0;
   localparam logic [1:0]  RST_SYNC        = 2'h0;

   typedef struct packed {
      logic jabber;
      logic an_complete;
      logic loopback;
      logic full_duplex;
      logic low_speed_indication;
      logic link_up;
      logic energy;
      logic fc_half_full;
      logic rx_half_full;
   } phy_state_s;

   typedef struct packed {
      logic [4:0]  addr;
      logic        rd;
      logic        wr;
      logic [15:0] wdata;
   } mgmt_req_s;

   localparam phy_state_s RST_STATE = '0;

endpackage

// file: src/event_latch.sv
// Purpose: sticky event flags, one per interrupt source
// Assumes: set and clear are single-cycle strobes on clk_sys
// Notes:   a set in the clearing cycle keeps the flag

module event_latch (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_b,
   input  wire logic [phy_irq_pkg::EVT_N-1:0] set_evt,
   input  wire logic [phy_irq_pkg::EVT_N-1:0] clr_evt,
   output logic      [phy_irq_pkg::EVT_N-1:0] flags
);
   import phy_irq_pkg::*;

   logic [EVT_N-1:0] flag_ff;
   logic [EVT_N-1:0] nxt_flag;

   genvar gi;
   generate
      for (gi = 0; gi < EVT_N; gi++) begin : g_bit
         // set beats clear so no event is lost to a racing read
         always_comb begin
            nxt_flag[gi] = set_evt[gi] | (flag_ff[gi] & ~clr_evt[gi]);
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flag_ff <= RST_EVT;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flags = flag_ff;

endmodule

// file: src/phy_status_interrupt_ctrl.sv
// Purpose: summary status word, interrupt control and event status of the PHY
// Assumes: management frame engine presents decoded register reads and writes
// Notes:   read data is registered, valid the cycle after the read strobe

module phy_status_interrupt_ctrl (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_b,
   input  wire phy_irq_pkg::mgmt_req_s        mgmt_req,
   output logic      [phy_irq_pkg::REG_W-1:0] mgmt_rdata,
   output logic                               mgmt_rvalid,
   input  wire phy_irq_pkg::phy_state_s       phy_state,
   input  wire logic                          irq_pin_i,
   output logic                               irq_pin_o,
   output logic                               irq_pin_oe_b,
   output logic                               powerdown_req,
   output logic                               irq_active
);
   import phy_irq_pkg::*;

   // control register state
   logic [CTL_USED_W-1:0] ctl_ff;
   logic [CTL_USED_W-1:0] nxt_ctl;
   logic [EVT_N-1:0]      evt_en_ff;
   logic [EVT_N-1:0]      nxt_evt_en;

   // read path state
   logic [REG_W-1:0]      rdata_ff;
   logic [REG_W-1:0]      nxt_rdata;
   logic                  rvalid_ff;
   logic                  nxt_rvalid;

   // previous phy state for change detection
   phy_state_s            prev_ff;
   phy_state_s            nxt_prev;

   // shared pin synchroniser
   logic [1:0]            pin_sync_ff;
   logic [1:0]            nxt_pin_sync;

   // combinational terms
   logic [EVT_N-1:0]      set_evt;
   logic [EVT_N-1:0]      clr_evt;
   logic [EVT_N-1:0]      flags;
   logic [REG_W-1:0]      summary_word;
   logic [REG_W-1:0]      ctl_word;
   logic [REG_W-1:0]      istat_word;
   logic                  evt_irq;
   logic                  irq_level;
   logic                  rd_istat;

   // event detection: edges and changes of the phy state
   always_comb begin
      set_evt              = '0;
      set_evt[EVT_ENERGY]  = phy_state.energy ^ prev_ff.energy;
      set_evt[EVT_LINK]    = phy_state.link_up ^ prev_ff.link_up;
      set_evt[EVT_SPEED]   = phy_state.low_speed_indication ^ prev_ff.low_speed_indication;
      set_evt[EVT_DUPLEX]  = phy_state.full_duplex ^ prev_ff.full_duplex;
      set_evt[EVT_AN_DONE] = phy_state.an_complete & ~prev_ff.an_complete;
      set_evt[EVT_FC_HALF] = phy_state.fc_half_full & ~prev_ff.fc_half_full;
      set_evt[EVT_RX_HALF] = phy_state.rx_half_full & ~prev_ff.rx_half_full;
      nxt_prev             = phy_state;
   end

   // only the flags returned by this read are cleared
   always_comb begin
      rd_istat = mgmt_req.rd && (mgmt_req.addr == ADDR_ISTAT);
      clr_evt  = rd_istat ? flags : '0;
   end

   event_latch u_event_latch (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .set_evt (set_evt),
      .clr_evt (clr_evt),
      .flags   (flags)
   );

   // interrupt generation
   always_comb begin
      evt_irq   = ctl_ff[CTL_GLOBAL_EN] & (|(flags & evt_en_ff));
      irq_level = evt_irq | ctl_ff[CTL_TEST_FORCE];
   end

   // register images
   always_comb begin
      summary_word               = RST_WORD;
      summary_word[SUM_LINK]     = phy_state.link_up;
      summary_word[SUM_LOW_SPEED_INDICATION]  = phy_state.low_speed_indication;
      summary_word[SUM_DUPLEX]   = phy_state.full_duplex;
      summary_word[SUM_LOOPBACK] = phy_state.loopback;
      summary_word[SUM_AN_DONE]  = phy_state.an_complete;
      summary_word[SUM_JABBER]   = phy_state.jabber;
      summary_word[SUM_IRQ_PEND] = irq_level;

      ctl_word                   = RST_WORD;
      ctl_word[CTL_USED_W-1:0]   = ctl_ff;

      istat_word                 = RST_WORD;
      istat_word[ISTAT_FLAG_LSB +: EVT_N] = flags;
      istat_word[ISTAT_EN_LSB +: EVT_N]   = evt_en_ff;
   end

   // register writes and read capture
   always_comb begin
      nxt_ctl    = ctl_ff;
      nxt_evt_en = evt_en_ff;
      nxt_rdata  = rdata_ff;
      nxt_rvalid = mgmt_req.rd;
      if (mgmt_req.wr) begin
         case (mgmt_req.addr)
            ADDR_ICTRL: begin
               nxt_ctl = mgmt_req.wdata[CTL_USED_W-1:0];
            end
            ADDR_ISTAT: begin
               nxt_evt_en = mgmt_req.wdata[ISTAT_EN_LSB +: EVT_N];
            end
            default: begin
               nxt_ctl = ctl_ff;
            end
         endcase
      end
      if (mgmt_req.rd) begin
         case (mgmt_req.addr)
            ADDR_SUMMARY: nxt_rdata = summary_word;
            ADDR_ICTRL:   nxt_rdata = ctl_word;
            ADDR_ISTAT:   nxt_rdata = istat_word;
            default:      nxt_rdata = RST_WORD;
         endcase
      end
   end

   // shared pin input path; only the second stage is read
   always_comb begin
      nxt_pin_sync = {pin_sync_ff[0], irq_pin_i};
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctl_ff      <= RST_CTL;
         evt_en_ff   <= RST_EVT;
         rdata_ff    <= RST_WORD;
         rvalid_ff   <= 1'b0;
         prev_ff     <= RST_STATE;
         pin_sync_ff <= RST_SYNC;
      end else begin
         ctl_ff      <= nxt_ctl;
         evt_en_ff   <= nxt_evt_en;
         rdata_ff    <= nxt_rdata;
         rvalid_ff   <= nxt_rvalid;
         prev_ff     <= nxt_prev;
         pin_sync_ff <= nxt_pin_sync;
      end
   end

   // pin is active low when driven, so a released pin never reads as an interrupt
   assign irq_pin_oe_b  = ~ctl_ff[CTL_IRQ_OE];
   assign irq_pin_o     = ~irq_level;
   assign powerdown_req = ctl_ff[CTL_IRQ_OE] ? 1'b0 : pin_sync_ff[1];
   assign irq_active    = irq_level;
   assign mgmt_rdata    = rdata_ff;
   assign mgmt_rvalid   = rvalid_ff;

endmodule

// file: tb/phy_irq_props.sv
// Purpose: port-level checks of the status and interrupt block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of the top module
module phy_irq_props (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   input  wire phy_irq_pkg::mgmt_req_s  mgmt_req,
   input  wire logic [15:0]             mgmt_rdata,
   input  wire logic                    mgmt_rvalid,
   input  wire phy_irq_pkg::phy_state_s phy_state,
   input  wire logic                    irq_pin_i,
   input  wire logic                    irq_pin_o,
   input  wire logic                    irq_pin_oe_b,
   input  wire logic                    powerdown_req,
   input  wire logic                    irq_active
);
   import phy_irq_pkg::*;
   logic [5:0] sum_exp;
   assign sum_exp = phy_state[8:3];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_rd(a);
      mgmt_req.rd && mgmt_req.addr == a;
   endsequence
   sequence s_wr(a);
      mgmt_req.wr && mgmt_req.addr == a;
   endsequence
   a_read_answer: assert property (mgmt_req.rd |=> mgmt_rvalid) else $error("no answer");
   a_answer_only: assert property (mgmt_rvalid |-> $past(mgmt_req.rd)) else $error("stray");
   a_summary_bits: assert property (s_rd(ADDR_SUMMARY) |=>
      mgmt_rdata[5:0] == $past(sum_exp)) else $error("summary bits wrong");
   a_pend_bit: assert property (s_rd(ADDR_SUMMARY) |=>
      mgmt_rdata[7] == $past(irq_active)) else $error("pending bit wrong");
   a_ctl_reserved: assert property (s_rd(ADDR_ICTRL) |=> mgmt_rdata[15:3] == 13'h0000)
      else $error("control reserved bits set");
   a_pin_role: assert property (s_wr(ADDR_ICTRL) |=>
      irq_pin_oe_b == !$past(mgmt_req.wdata[0])) else $error("pin role wrong");
   a_test_force: assert property (mgmt_req.wr && mgmt_req.addr == ADDR_ICTRL &&
      mgmt_req.wdata[2] |=> irq_active [*2]) else $error("test force lost");
   a_global_off: assert property (mgmt_req.wr && mgmt_req.addr == ADDR_ICTRL &&
      mgmt_req.wdata[2:1] == 2'b00 |=> !irq_active) else $error("irq while disabled");
   a_pin_drive: assert property (!irq_pin_oe_b |-> irq_pin_o == !irq_active)
      else $error("pin level wrong");
   // request is gated by the same register bit as the enable, so it drops in the same cycle
   a_pd_gated: assert property (!irq_pin_oe_b [*2] |-> !powerdown_req)
      else $error("power-down while output");
endmodule
bind phy_status_interrupt_ctrl phy_irq_props phy_irq_props_inst (.clk_sys, .rst_b,
   .mgmt_req, .mgmt_rdata, .mgmt_rvalid, .phy_state, .irq_pin_i, .irq_pin_o,
   .irq_pin_oe_b, .powerdown_req, .irq_active);

// file: tb/mgmt_host.sv
// Purpose: station manager model issuing register cycles
// Assumes: one-cycle strobes, answer one cycle after the read
// Notes:   released fields show inverted values, not the last ones
module mgmt_host (
   input  wire logic                   clk_sys,
   output phy_irq_pkg::mgmt_req_s      mgmt_req,
   input  wire logic [15:0]            mgmt_rdata
);
   import phy_irq_pkg::*;
   initial mgmt_req = '0;
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      mgmt_req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
      @(posedge clk_sys);
      mgmt_req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      mgmt_req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 16'h0000};
      @(posedge clk_sys);
      mgmt_req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: 16'hFFFF};
      // read data holds until the next read, so mid-cycle is safe
      @(negedge clk_sys);
      d = mgmt_rdata;
   endtask
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench of the status and interrupt block
// Assumes: 20 MHz clock, reset held ten cycles
// Notes:   pin level resolved from the block's enable
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import phy_irq_pkg::*;
   logic clk_sys, rst_b, mgmt_rvalid, irq_pin_o, irq_pin_oe_b, powerdown_req, irq_active;
   logic pd_lvl;
   wire  irq_pin_i;
   mgmt_req_s   mgmt_req;
   logic [15:0] mgmt_rdata;
   phy_state_s  phy_state;
   int          failures = 0;
   int          num_checks = 0;
   int          cyc = 0;
   assign irq_pin_i = irq_pin_oe_b ? pd_lvl : irq_pin_o;
   phy_status_interrupt_ctrl phy_status_interrupt_ctrl_inst (.clk_sys, .rst_b, .mgmt_req,
      .mgmt_rdata, .mgmt_rvalid, .phy_state, .irq_pin_i, .irq_pin_o, .irq_pin_oe_b,
      .powerdown_req, .irq_active);
   mgmt_host mgmt_host_inst (.clk_sys, .mgmt_req, .mgmt_rdata);
   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;
   task automatic give_verdict;
      if (failures == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic ck(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      mgmt_host_inst.rd(a, d);
      ck(16'(mgmt_rvalid), 16'h0001);
      ck(d, exp);
   endtask
   task automatic t_reset;
      rchk(ADDR_ICTRL, 16'h0000);
      rchk(ADDR_ISTAT, 16'h0000);
      rchk(ADDR_SUMMARY, 16'h0000);
      rchk(5'h13, 16'h0000);
      ck(16'(irq_pin_oe_b), 16'h0001);
   endtask
   task automatic t_events;
      int pos [7] = '{0, 1, 7, 5, 4, 3, 2};
      mgmt_host_inst.wr(ADDR_ICTRL, 16'h0002);
      @(posedge clk_sys);
      phy_state.link_up <= 1'b1;
      repeat (2) @(negedge clk_sys);
      ck(16'(irq_active), 16'h0000);
      rchk(ADDR_ISTAT, 16'h2000);
      rchk(ADDR_ISTAT, 16'h0000);
      mgmt_host_inst.wr(ADDR_ISTAT, 16'hFFFF);
      rchk(ADDR_ISTAT, 16'h007F);
      foreach (pos[i]) begin
         @(posedge clk_sys);
         phy_state[pos[i]] <= ~phy_state[pos[i]];
         repeat (2) @(negedge clk_sys);
         ck(16'(irq_active), 16'h0001);
         rchk(ADDR_ISTAT, 16'h007F | (16'h0100 << i));
         ck(16'(irq_active), 16'h0000);
      end
      mgmt_host_inst.wr(ADDR_ICTRL, 16'h0000);
      @(posedge clk_sys);
      phy_state.link_up <= 1'b1;
      phy_state.jabber <= 1'b1;
      phy_state.loopback <= 1'b1;
      repeat (2) @(negedge clk_sys);
      ck(16'(irq_active), 16'h0000);
      rchk(ADDR_ISTAT, 16'h207F);
      // summary bits mirror the phy state directly, so all six status bits read as set
      rchk(ADDR_SUMMARY, 16'h003F);
      rchk(ADDR_SUMMARY, 16'h003F);
   endtask
   task automatic t_ctrl;
      mgmt_host_inst.wr(ADDR_ICTRL, 16'hFFFF);
      rchk(ADDR_ICTRL, 16'h0007);
      ck({irq_active, irq_pin_oe_b, irq_pin_o}, 16'h0004);
      mgmt_host_inst.wr(ADDR_SUMMARY, 16'h0000);
      rchk(ADDR_SUMMARY, 16'h00BF);
      rchk(ADDR_ISTAT, 16'h007F);
      ck(16'(irq_active), 16'h0001);
      mgmt_host_inst.wr(ADDR_ICTRL, 16'h0001);
      @(negedge clk_sys);
      ck({irq_active, irq_pin_oe_b, irq_pin_o}, 16'h0001);
      mgmt_host_inst.wr(ADDR_ICTRL, 16'h0000);
      @(posedge clk_sys);
      pd_lvl <= 1'b1;
      repeat (3) @(negedge clk_sys);
      ck(16'(powerdown_req), 16'h0001);
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      rst_b = 1'b0;
      phy_state = '0;
      pd_lvl = 1'b0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset();
      t_events();
      t_ctrl();
      give_verdict();
   end
endmodule
